//--- vc_resource_regs_tb_top.sv
`timescale 1ns/1ps
`include "vcr_defs.svh"
module vc_resource_regs_tb_top import vcr_pkg::*;;
  localparam int PH = 8;
  logic i_clk, i_srst, i_cfg_wr, i_cfg_rd, o_cfg_rvalid, i_dflt_tcmap_we;
  logic i_dflt_slots_we, i_tbl_entry_wr, i_vc_negotiating, o_vc_en;
  logic o_tbl_loading, o_tbl_load_stb;
  logic [11:0] i_cfg_addr;
  logic [3:0] i_cfg_be;
  logic [31:0] i_cfg_wdata, o_cfg_rdata, v;
  logic [2:0] i_ext_vc_cnt, o_arb_sel, o_tbl_load_idx;
  logic [7:0] i_dflt_tcmap, o_tc_map;
  logic [6:0] i_dflt_slots;
  integer n_fail, samples_checked, seed, k, n;
  integer m_tc, m_sel, m_en, m_slots, m_ext;

  vcr_regs #(.PHASES(PH)) dut (
    .i_clk(i_clk), .i_srst(i_srst), .i_cfg_wr(i_cfg_wr),
    .i_cfg_rd(i_cfg_rd), .i_cfg_addr(i_cfg_addr), .i_cfg_be(i_cfg_be),
    .i_cfg_wdata(i_cfg_wdata), .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rvalid(o_cfg_rvalid), .i_ext_vc_cnt(i_ext_vc_cnt),
    .i_dflt_tcmap_we(i_dflt_tcmap_we), .i_dflt_tcmap(i_dflt_tcmap),
    .i_dflt_slots_we(i_dflt_slots_we), .i_dflt_slots(i_dflt_slots),
    .i_tbl_entry_wr(i_tbl_entry_wr), .i_vc_negotiating(i_vc_negotiating),
    .o_tc_map(o_tc_map), .o_arb_sel(o_arb_sel), .o_vc_en(o_vc_en),
    .o_tbl_loading(o_tbl_loading), .o_tbl_load_stb(o_tbl_load_stb),
    .o_tbl_load_idx(o_tbl_load_idx)
  );

  always #5 i_clk = ~i_clk;

  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", s, exp, seen);
    end
  endtask

  // model view of control and capability words
  function logic [31:0] ectl();
    return {m_en[0], 11'h000, m_sel[2:0], 9'h000, m_tc[7:0]};
  endfunction

  function logic [31:0] ecap();
    if (m_ext != 0)
      return {8'h08, 1'b0, m_slots[6:0], 16'h0019};
    return {9'h000, m_slots[6:0], 16'h0000};
  endfunction

  task rst(input logic [2:0] ext);
    @(posedge i_clk);
    i_srst <= 1'b1;
    i_ext_vc_cnt <= ext;
    repeat (4) @(posedge i_clk);
    i_srst <= 1'b0;
    m_tc = 8'hFF;
    m_sel = 0;
    m_en = 1;
    m_ext = (ext != 0);
    m_slots = (ext != 0) ? 7'h7F : 7'h00;
  endtask

  task wr(input logic [11:0] a, input logic [3:0] b, input logic [31:0] d);
    @(posedge i_clk);
    i_cfg_wr <= 1'b1;
    i_cfg_addr <= a;
    i_cfg_be <= b;
    i_cfg_wdata <= d;
    @(posedge i_clk);
    i_cfg_wr <= 1'b0;
    // let the write settle before anyone looks at the outputs
    #1;
  endtask

  task rd(input string s, input logic [11:0] a, input logic [31:0] e);
    @(posedge i_clk);
    i_cfg_rd <= 1'b1;
    i_cfg_addr <= a;
    @(posedge i_clk);
    i_cfg_rd <= 1'b0;
    #1;
    chk(s, o_cfg_rdata, e);
    chk("rvalid", {31'h0, o_cfg_rvalid}, 32'h1);
    @(posedge i_clk);
    #1;
    chk("rvalid_end", {31'h0, o_cfg_rvalid}, 32'h0);
    chk("rdata_end", o_cfg_rdata, 32'h0);
  endtask

  task pulse_ld(input logic slots);
    @(posedge i_clk);
    if (slots) i_dflt_slots_we <= 1'b1;
    else i_dflt_tcmap_we <= 1'b1;
    @(posedge i_clk);
    i_dflt_slots_we <= 1'b0;
    i_dflt_tcmap_we <= 1'b0;
    #1;
  endtask

  task chk_outs;
    chk("tc_map", {24'h0, o_tc_map}, m_tc);
    chk("arb_sel", {29'h0, o_arb_sel}, m_sel);
    chk("vc_en", {31'h0, o_vc_en}, m_en);
  endtask

  initial begin
    i_clk = 0; i_srst = 1; i_cfg_wr = 0; i_cfg_rd = 0; i_cfg_addr = 0;
    i_cfg_be = 0; i_cfg_wdata = 0; i_ext_vc_cnt = 0; i_dflt_tcmap_we = 0;
    i_dflt_tcmap = 0; i_dflt_slots_we = 0; i_dflt_slots = 0;
    i_tbl_entry_wr = 0; i_vc_negotiating = 0;
    n_fail = 0; samples_checked = 0; seed = 69;
    rst(3'h0);
    chk_outs;
    rd("ctrl", 12'h154, ectl());
    rd("stat", 12'h158, 32'h0);
    rd("cap0", 12'h15C, ecap());
    rst(3'h1);
    rd("cap1", 12'h15C, ecap());
    $display("test reset values done");
    // every select code, random map, enable and reserved bits
    for (k = 0; k < 8; k++) begin
      v = $random(seed);
      v[19:17] = k[2:0];
      v[16] = 1'b0;
      wr(12'h154, 4'hF, v);
      m_tc = v[7:0];
      m_sel = (k == 0 || k == 3) ? k : 0;
      m_en = v[31];
      chk_outs;
      rd("ctrl_rw", 12'h154, ectl());
    end
    wr(12'h154, 4'h2, 32'hFFFF_FFFF);
    rd("ctrl_be", 12'h154, ectl());
    wr(12'h150, 4'hF, 32'hFFFF_FFFF);
    wr(12'h158, 4'hF, 32'hFFFF_FFFF);
    wr(12'h15C, 4'hF, 32'hFFFF_FFFF);
    rd("unmapped", 12'h150, 32'h0);
    rd("stat_ro", 12'h158, 32'h0);
    rd("cap_ro", 12'h15C, ecap());
    chk_outs;
    $display("test register access done");
    v = $random(seed);
    i_dflt_tcmap <= v[7:0];
    i_dflt_slots <= v[14:8];
    pulse_ld(1'b0);
    m_tc = v[7:0];
    chk_outs;
    pulse_ld(1'b1);
    m_slots = v[14:8];
    rd("cap_ld", 12'h15C, ecap());
    $display("test loader done");
    @(posedge i_clk);
    i_vc_negotiating <= 1'b1;
    rd("neg1", 12'h158, 32'h0002_0000);
    @(posedge i_clk);
    i_vc_negotiating <= 1'b0;
    rd("neg0", 12'h158, 32'h0);
    $display("test negotiation done");
    @(posedge i_clk);
    i_tbl_entry_wr <= 1'b1;
    @(posedge i_clk);
    i_tbl_entry_wr <= 1'b0;
    rd("tbl_set", 12'h158, 32'h0001_0000);
    wr(12'h154, 4'h4, {12'h000, m_sel[2:0], 1'b1, 16'h0000});
    // entry zero already moves in the cycle right after the trigger
    n = 0;
    for (k = 0; k < 200; k++) begin
      if (o_tbl_load_stb === 1'b1) begin
        chk("load_idx", {29'h0, o_tbl_load_idx}, n);
        chk("loading", {31'h0, o_tbl_loading}, 32'h1);
        n++;
      end
      if (n > 0 && o_tbl_loading !== 1'b1) break;
      @(posedge i_clk);
      #1;
    end
    if (k == 200) begin
      n_fail++;
      stop_test;
    end
    chk("load_count", n, PH);
    rd("tbl_clr", 12'h158, 32'h0);
    rd("ctrl_ld", 12'h154, ectl());
    $display("test table load done");
    wr(12'h154, 4'h9, 32'h0000_0000);
    rst(3'h0);
    chk_outs;
    rd("ctrl_rst", 12'h154, ectl());
    rd("cap_rst", 12'h15C, ecap());
    $display("test second reset done");
    stop_test;
  end
endmodule

//--- vcr_defs.svh
`ifndef VCR_DEFS_SVH
`define VCR_DEFS_SVH

`define VCR_ADDR_W 12
`define VCR_OFF_CTRL0 12'h154
`define VCR_OFF_STAT0 12'h158
`define VCR_OFF_CAP1 12'h15C

`define VCR_CTRL_TCMAP_LSB 0
`define VCR_CTRL_TCMAP_MSB 7
`define VCR_CTRL_LOAD_BIT 16
`define VCR_CTRL_SEL_LSB 17
`define VCR_CTRL_SEL_MSB 19
`define VCR_CTRL_VCID_LSB 24
`define VCR_CTRL_VCID_MSB 26
`define VCR_CTRL_EN_BIT 31

`define VCR_STAT_TBL_BIT 16
`define VCR_STAT_NEG_BIT 17

`define VCR_CAP_ARB_LSB 0
`define VCR_CAP_ARB_MSB 7
`define VCR_CAP_APS_BIT 14
`define VCR_CAP_RSNP_BIT 15
`define VCR_CAP_SLOT_LSB 16
`define VCR_CAP_SLOT_MSB 22
`define VCR_CAP_OFS_LSB 24
`define VCR_CAP_OFS_MSB 31

`define VCR_RST_TCMAP 8'hFF
`define VCR_RST_SEL 3'h0
`define VCR_RST_VCID 3'h0
`define VCR_RST_EN 1'h1
`define VCR_SEL_RR 3'h0
`define VCR_SEL_WRR128 3'h3

`define VCR_CAP_ARB_X0 8'h00
`define VCR_CAP_ARB_X1 8'h19
`define VCR_CAP_SLOT_X0 7'h00
`define VCR_CAP_SLOT_X1 7'h7F
`define VCR_CAP_OFS_X0 8'h00
`define VCR_CAP_OFS_X1 8'h08

`define VCR_ARB_PHASES 128

`endif

//--- vcr_load_seq.sv
`timescale 1ns/1ps
`include "vcr_defs.svh"

module vcr_load_seq
  import vcr_pkg::*;
#(
  parameter int PHASES = `VCR_ARB_PHASES,
  parameter int IDX_W = $clog2(PHASES)
) (
  input wire logic i_clk, // core clock
  input wire logic i_srst, // sync reset
  input wire logic i_start, // begin a table transfer
  output logic o_busy, // transfer in progress
  output logic o_done, // one-cycle pulse at the end
  output logic o_stb, // one entry moved this cycle
  output logic [IDX_W-1:0] o_idx // entry being moved
);

  vcr_ld_state_e state;
  vcr_ld_state_e next_state;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] next_idx;

  localparam logic [IDX_W-1:0] LAST = IDX_W'(PHASES - 1);

  always_comb begin
    next_state = state;
    next_idx = idx;
    unique case (state)
      VCR_LD_IDLE: begin
        next_idx = '0;
        if (i_start) begin
          next_state = VCR_LD_RUN;
        end
      end
      VCR_LD_RUN: begin
        if (idx == LAST) begin
          next_state = VCR_LD_DONE;
        end else begin
          next_idx = idx + 1'b1;
        end
      end
      VCR_LD_DONE: begin
        next_state = VCR_LD_IDLE;
      end
      default: begin
        next_state = VCR_LD_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= VCR_LD_IDLE;
      idx <= '0;
    end else begin
      state <= next_state;
      idx <= next_idx;
    end
  end

  assign o_busy = (state != VCR_LD_IDLE);
  assign o_stb = (state == VCR_LD_RUN);
  assign o_done = (state == VCR_LD_DONE);
  assign o_idx = idx;

  sequence s_start;
    !o_busy && i_start;
  endsequence

  property p_ld_begin;
    @(posedge i_clk) disable iff (i_srst)
    s_start |=> o_stb && (o_idx == '0);
  endproperty
  a_ld_begin: assert property (p_ld_begin)
    else $error("table transfer did not start at entry zero");

  property p_ld_end;
    @(posedge i_clk) disable iff (i_srst)
    o_done |-> $past(o_stb) && ($past(o_idx) == LAST);
  endproperty
  a_ld_end: assert property (p_ld_end)
    else $error("transfer ended before the last entry");

endmodule

//--- vcr_pkg.sv
`include "vcr_defs.svh"

package vcr_pkg;

  typedef enum logic [2:0] {
    VCR_ARB_RR = `VCR_SEL_RR,
    VCR_ARB_WRR128 = `VCR_SEL_WRR128
  } vcr_arb_e;

  typedef enum logic [1:0] {
    VCR_LD_IDLE = 2'h0,
    VCR_LD_RUN = 2'h1,
    VCR_LD_DONE = 2'h3
  } vcr_ld_state_e;

endpackage

//--- vcr_regs.sv
`timescale 1ns/1ps
`include "vcr_defs.svh"

// Notes on behaviour
// - vc0 control bits 7:0 map each traffic class onto vc0 when set.
// - traffic class map resets to all ones; a default loader may override.
// - writing one to load bit moves the table to hardware; reads zero.
// - arbitration select keeps only 000b or 011b; else default; resets 000b.
// - vc0 identifier bits 26:24 are read-only zero.
// - vc0 enable bit is writable, one enables, resets to one.
// - table status sets whenever software writes any arbitration table entry.
// - table status clears only when a triggered table transfer finishes.
// - negotiation pending reads one while negotiating; resets to zero.
// - vc1 arbitration capability is 00h or 19h by extended vc count.
// - round robin and 128-phase weighted schemes; time-based only on vc1.
// - vc1 advanced switching and reject snoop bits read zero.
// - vc1 max time slots 00h or 7Fh by count, loader may override.
// - vc1 table offset in 16-byte units, 00h or 08h by count.
module vcr_regs
  import vcr_pkg::*;
#(
  parameter int PHASES = `VCR_ARB_PHASES,
  parameter int IDX_W = $clog2(PHASES)
) (
  input wire logic i_clk, // core clock
  input wire logic i_srst, // sync reset, active high
  input wire logic i_cfg_wr, // config write strobe
  input wire logic i_cfg_rd, // config read strobe
  input wire logic [`VCR_ADDR_W-1:0] i_cfg_addr, // config byte address
  input wire logic [3:0] i_cfg_be, // byte enables
  input wire logic [31:0] i_cfg_wdata, // write data
  output logic [31:0] o_cfg_rdata, // read data, registered
  output logic o_cfg_rvalid, // read data valid pulse
  input wire logic [2:0] i_ext_vc_cnt, // extended vc count setting
  input wire logic i_dflt_tcmap_we, // loader writes tc map default
  input wire logic [7:0] i_dflt_tcmap, // loader tc map value
  input wire logic i_dflt_slots_we, // loader writes time slots
  input wire logic [6:0] i_dflt_slots, // loader time slot value
  input wire logic i_tbl_entry_wr, // software wrote a table entry
  input wire logic i_vc_negotiating, // vc negotiation in progress
  output logic [7:0] o_tc_map, // tc to vc0 map
  output logic [2:0] o_arb_sel, // active port arbitration scheme
  output logic o_vc_en, // vc0 enabled
  output logic o_tbl_loading, // table transfer busy
  output logic o_tbl_load_stb, // one table entry moved
  output logic [IDX_W-1:0] o_tbl_load_idx // entry being moved
);

  logic [7:0] tc_map;
  logic [7:0] next_tc_map;
  logic [2:0] arb_sel;
  logic [2:0] next_arb_sel;
  logic vc_en;
  logic next_vc_en;
  logic tbl_stat;
  logic next_tbl_stat;
  logic neg_pend;
  logic next_neg_pend;
  logic [6:0] slots;
  logic [6:0] next_slots;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic rvalid;
  logic next_rvalid;

  logic wr_ctrl;
  logic ld_start;
  logic ld_busy;
  logic ld_done;
  logic ext_one;
  logic [2:0] wsel;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] cap_word;

  assign wr_ctrl = i_cfg_wr && (i_cfg_addr == `VCR_OFF_CTRL0);
  assign wsel = i_cfg_wdata[`VCR_CTRL_SEL_MSB:`VCR_CTRL_SEL_LSB];
  // load bit is a pure trigger, never stored
  assign ld_start = wr_ctrl && i_cfg_be[2] &&
                    i_cfg_wdata[`VCR_CTRL_LOAD_BIT];
  assign ext_one = (i_ext_vc_cnt != 3'h0);

  vcr_load_seq #(
    .PHASES(PHASES),
    .IDX_W(IDX_W)
  ) u_load_seq (
    .i_clk(i_clk),
    .i_srst(i_srst),
    .i_start(ld_start),
    .o_busy(ld_busy),
    .o_done(ld_done),
    .o_stb(o_tbl_load_stb),
    .o_idx(o_tbl_load_idx)
  );

  always_comb begin
    next_tc_map = tc_map;
    next_arb_sel = arb_sel;
    next_vc_en = vc_en;
    next_slots = slots;
    if (i_dflt_tcmap_we) begin
      next_tc_map = i_dflt_tcmap;
    end
    if (i_dflt_slots_we) begin
      next_slots = i_dflt_slots;
    end
    if (wr_ctrl && i_cfg_be[0]) begin
      next_tc_map = i_cfg_wdata[`VCR_CTRL_TCMAP_MSB:`VCR_CTRL_TCMAP_LSB];
    end
    if (wr_ctrl && i_cfg_be[2]) begin
      if (wsel == VCR_ARB_RR || wsel == VCR_ARB_WRR128) begin
        next_arb_sel = wsel;
      end else begin
        next_arb_sel = `VCR_RST_SEL;
      end
    end
    if (wr_ctrl && i_cfg_be[3]) begin
      next_vc_en = i_cfg_wdata[`VCR_CTRL_EN_BIT];
    end
  end

  always_comb begin
    // a new entry write beats the end of a transfer
    next_tbl_stat = i_tbl_entry_wr || (tbl_stat && !ld_done);
    next_neg_pend = i_vc_negotiating;
  end

  always_comb begin
    ctrl_word = '0;
    ctrl_word[`VCR_CTRL_TCMAP_MSB:`VCR_CTRL_TCMAP_LSB] = tc_map;
    ctrl_word[`VCR_CTRL_SEL_MSB:`VCR_CTRL_SEL_LSB] = arb_sel;
    ctrl_word[`VCR_CTRL_VCID_MSB:`VCR_CTRL_VCID_LSB] = `VCR_RST_VCID;
    ctrl_word[`VCR_CTRL_EN_BIT] = vc_en;
    stat_word = '0;
    stat_word[`VCR_STAT_TBL_BIT] = tbl_stat;
    stat_word[`VCR_STAT_NEG_BIT] = neg_pend;
    cap_word = '0;
    cap_word[`VCR_CAP_ARB_MSB:`VCR_CAP_ARB_LSB] =
      ext_one ? `VCR_CAP_ARB_X1 : `VCR_CAP_ARB_X0;
    cap_word[`VCR_CAP_SLOT_MSB:`VCR_CAP_SLOT_LSB] = slots;
    cap_word[`VCR_CAP_OFS_MSB:`VCR_CAP_OFS_LSB] =
      ext_one ? `VCR_CAP_OFS_X1 : `VCR_CAP_OFS_X0;
  end

  always_comb begin
    next_rvalid = i_cfg_rd;
    next_rdata = '0;
    if (i_cfg_rd) begin
      unique case (i_cfg_addr)
        `VCR_OFF_CTRL0: next_rdata = ctrl_word;
        `VCR_OFF_STAT0: next_rdata = stat_word;
        `VCR_OFF_CAP1: next_rdata = cap_word;
        default: next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      tc_map <= `VCR_RST_TCMAP;
      arb_sel <= `VCR_RST_SEL;
      vc_en <= `VCR_RST_EN;
      tbl_stat <= 1'b0;
      neg_pend <= 1'b0;
      slots <= ext_one ? `VCR_CAP_SLOT_X1 : `VCR_CAP_SLOT_X0;
      rdata <= '0;
      rvalid <= 1'b0;
    end else begin
      tc_map <= next_tc_map;
      arb_sel <= next_arb_sel;
      vc_en <= next_vc_en;
      tbl_stat <= next_tbl_stat;
      neg_pend <= next_neg_pend;
      slots <= next_slots;
      rdata <= next_rdata;
      rvalid <= next_rvalid;
    end
  end

  assign o_cfg_rdata = rdata;
  assign o_cfg_rvalid = rvalid;
  assign o_tc_map = tc_map;
  assign o_arb_sel = arb_sel;
  assign o_vc_en = vc_en;
  assign o_tbl_loading = ld_busy;

  property p_map_reset;
    @(posedge i_clk) $past(i_srst) |-> o_tc_map == 8'hFF && o_vc_en;
  endproperty
  a_map_reset: assert property (p_map_reset)
    else $error("map or enable wrong after reset");

  property p_map_write;
    @(posedge i_clk) disable iff (i_srst)
    wr_ctrl && i_cfg_be[0] |=> o_tc_map == $past(i_cfg_wdata[7:0]);
  endproperty
  a_map_write: assert property (p_map_write)
    else $error("tc map write not taken");

  property p_ctrl_read;
    @(posedge i_clk) disable iff (i_srst)
    i_cfg_rd && i_cfg_addr == `VCR_OFF_CTRL0 |=>
      o_cfg_rvalid && !o_cfg_rdata[16] && o_cfg_rdata[26:24] == 3'h0 &&
      o_cfg_rdata[15:8] == 8'h00 && o_cfg_rdata[31] == $past(o_vc_en);
  endproperty
  a_ctrl_read: assert property (p_ctrl_read)
    else $error("control read shows wrong fixed bits");

  property p_sel_legal;
    @(posedge i_clk) disable iff (i_srst)
    o_arb_sel == 3'h0 || o_arb_sel == 3'h3;
  endproperty
  a_sel_legal: assert property (p_sel_legal)
    else $error("illegal arbitration select held");

  property p_sel_write;
    @(posedge i_clk) disable iff (i_srst)
    wr_ctrl && i_cfg_be[2] && i_cfg_wdata[19:17] == 3'h3 |=>
      o_arb_sel == 3'h3;
  endproperty
  a_sel_write: assert property (p_sel_write)
    else $error("weighted scheme write not taken");

  sequence s_entry_wr;
    i_tbl_entry_wr;
  endsequence

  property p_stat_set;
    @(posedge i_clk) disable iff (i_srst)
    s_entry_wr |=> tbl_stat;
  endproperty
  a_stat_set: assert property (p_stat_set)
    else $error("table status not set by entry write");

  property p_stat_clear;
    @(posedge i_clk) disable iff (i_srst)
    $fell(tbl_stat) |-> $past(ld_done);
  endproperty
  a_stat_clear: assert property (p_stat_clear)
    else $error("table status cleared without finished transfer");

  property p_neg;
    @(posedge i_clk) disable iff (i_srst)
    i_vc_negotiating |=> neg_pend ##1 1'b1;
  endproperty
  a_neg: assert property (p_neg)
    else $error("negotiation pending not shown");

  property p_cap;
    @(posedge i_clk) disable iff (i_srst)
    i_cfg_rd && i_cfg_addr == `VCR_OFF_CAP1 |=>
      o_cfg_rdata[7:0] == ($past(ext_one) ? 8'h19 : 8'h00) &&
      o_cfg_rdata[31:24] == ($past(ext_one) ? 8'h08 : 8'h00) &&
      o_cfg_rdata[15:14] == 2'h0;
  endproperty
  a_cap: assert property (p_cap)
    else $error("vc1 capability read wrong");

endmodule
